//--- hdl/twm_defs.vh
/*
 two-wire master transmitter: register offsets, control bit positions, status codes, timing.
 assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH
// ==========================================
// register byte addresses (word aligned)
`define TWM_OFF_CONTROL 4'h0
`define TWM_OFF_STATUS 4'h4
`define TWM_OFF_DATA 4'h8
// ==========================================
// control bit positions
`define TWM_CB_STEP_DONE 7
`define TWM_CB_ACK_EN 6
`define TWM_CB_START 5
`define TWM_CB_STOP 4
`define TWM_CB_WCOL 3
`define TWM_CB_ENABLE 2
`define TWM_CB_IRQ_EN 0
// ==========================================
// status codes, prescaler bits zero
`define TWM_ST_IDLE 8'hf8
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
// ==========================================
// timing: quarter bit period in ns, and in 100 MHz cycles
`define TWM_QUARTER_NS 2500
`define TWM_CLK_NS 10
`define TWM_QUARTER_CYC (`TWM_QUARTER_NS / `TWM_CLK_NS)
`endif

//--- hdl/twm_sync.v
/*
 two-flop synchroniser for the bus pin levels.
 assumes inputs are asynchronous to clk_in; only the second stage is read outside.
*/
`timescale 1ns/1ns
module twm_sync (
  input wire clk_in,
  input wire rst_in,
  input wire [1:0] async_in,
  output reg [1:0] sync_out
);
  reg [1:0] meta;
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta <= 2'h3;
      sync_out <= 2'h3;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- hdl/twm_master.v
/*
 two-wire master transmitter with avalon-mm register slave.
 assumes open-drain pins resolved outside (oe high pulls low), 100 MHz CLK_IN, sync reset.
*/
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
// Function
// - control write step=1,start=1,stop=0,enable=1 requests start once bus is free.
// - after start goes out, set step flag and report 0x08.
// - first address after start picks transmitter or receiver mode.
// - after write address and ack slot, report 0x18, 0x20 or 0x38.
// - data writes while step flag low are dropped and set write collision.
// - writing one to step flag clears it and continues the transfer.
// - stop request sends stop, then hardware clears stop request.
// - start request after address or data step gives repeated start, status 0x10.
// - in 0x10 send loaded address; read address switches to receiver mode.
// - after a data byte report 0x28 on ack, 0x30 on no ack.
// - in data states, clear with no start/stop sends the loaded byte.
// - in data states, clear with start only issues repeated start.
// - in data states, start and stop both give stop then start.
// - arbitration loss reports 0x38; clear without start releases bus.
// - in 0x38 clear with start waits for free bus then starts.
// - status codes sit with prescaler bits zero.
// - repeated start keeps bus ownership; address may change.
// - while step flag high the bus stays frozen.
// - direction bit low for write, high for read; ack is low data.
`timescale 1ns/1ns
`include "twm_defs.vh"
module twm_master #(
  parameter QUARTER = `TWM_QUARTER_CYC
) (
  input wire CLK_IN,
  input wire RST_IN,
  input wire [3:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  output reg [31:0] AVS_READDATA_OUT,
  output reg AVS_WAITREQUEST_OUT,
  input wire SCL_IN,
  output reg SCL_OE_OUT,
  output reg SCL_OUT,
  input wire SDA_IN,
  output reg SDA_OE_OUT,
  output reg SDA_OUT,
  output reg IRQ_OUT,
  output reg RECEIVER_MODE_OUT
);
  // ==========================================
  // states
  localparam S_IDLE = 4'd0;
  localparam S_WAIT_FREE = 4'd1;
  localparam S_START = 4'd2;
  localparam S_BIT = 4'd3;
  localparam S_ACK = 4'd4;
  localparam S_STOP = 4'd5;
  localparam S_HOLD = 4'd6;
  localparam S_RSTART = 4'd7;

  reg [3:0] state;
  reg [1:0] phase;
  reg [15:0] qcnt;
  reg [3:0] bitn;
  reg [7:0] shreg;
  reg [7:0] data;
  reg [7:0] status;
  reg step_done, ack_en, start_req, stop_req, wcol, enable, irq_en;
  reg owner, in_addr, rep, sda_drv, scl_drv;
  reg bus_busy;
  reg sda_prev, scl_prev;
  wire [1:0] pins;

  twm_sync u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .async_in({SCL_IN, SDA_IN}),
    .sync_out(pins)
  );
  wire scl = pins[1];
  wire sda = pins[0];
  wire tick = (qcnt == 16'h0000);
  wire bus_wr = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
  wire bus_rd = AVS_READ_IN & ~AVS_WAITREQUEST_OUT;
  wire ctl_wr = bus_wr & (AVS_ADDRESS_IN == `TWM_OFF_CONTROL);
  wire dat_wr = bus_wr & (AVS_ADDRESS_IN == `TWM_OFF_DATA);
  wire go = ctl_wr & AVS_WRITEDATA_IN[`TWM_CB_STEP_DONE] & AVS_WRITEDATA_IN[`TWM_CB_ENABLE];
  wire w_sta = AVS_WRITEDATA_IN[`TWM_CB_START];
  wire w_sto = AVS_WRITEDATA_IN[`TWM_CB_STOP];

  function [7:0] ctl_word;
    input dummy;
    begin
      ctl_word = {step_done, ack_en, start_req, stop_req, wcol, enable, 1'b0, irq_en};
    end
  endfunction

  // ==========================================
  // avalon slave: one wait cycle per access, then answer
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_OUT <= ~((AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT);
      if (AVS_READ_IN & AVS_WAITREQUEST_OUT) begin
        if (AVS_ADDRESS_IN == `TWM_OFF_CONTROL) begin
          AVS_READDATA_OUT <= {24'h000000, ctl_word(1'b0)};
        end else if (AVS_ADDRESS_IN == `TWM_OFF_STATUS) begin
          AVS_READDATA_OUT <= {24'h000000, status[7:3], 3'h0};
        end else if (AVS_ADDRESS_IN == `TWM_OFF_DATA) begin
          AVS_READDATA_OUT <= {24'h000000, data};
        end else begin
          AVS_READDATA_OUT <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================
  // bus-busy tracking from start/stop seen on the pins
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      sda_prev <= sda;
      scl_prev <= scl;
      if (scl & scl_prev & sda_prev & ~sda) begin
        bus_busy <= 1'b1;
      end else if (scl & scl_prev & ~sda_prev & sda) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // ==========================================
  // control, data and sequencer
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      state <= S_IDLE;
      phase <= 2'd0;
      qcnt <= 16'h0000;
      bitn <= 4'd0;
      shreg <= 8'h00;
      data <= 8'hff;
      status <= `TWM_ST_IDLE;
      step_done <= 1'b0;
      ack_en <= 1'b0;
      start_req <= 1'b0;
      stop_req <= 1'b0;
      wcol <= 1'b0;
      enable <= 1'b0;
      irq_en <= 1'b0;
      owner <= 1'b0;
      in_addr <= 1'b0;
      rep <= 1'b0;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
      RECEIVER_MODE_OUT <= 1'b0;
    end else begin
      qcnt <= tick ? QUARTER[15:0] - 16'h0001 : qcnt - 16'h0001;
      if (ctl_wr) begin
        ack_en <= AVS_WRITEDATA_IN[`TWM_CB_ACK_EN];
        start_req <= w_sta;
        stop_req <= w_sto;
        enable <= AVS_WRITEDATA_IN[`TWM_CB_ENABLE];
        irq_en <= AVS_WRITEDATA_IN[`TWM_CB_IRQ_EN];
        if (AVS_WRITEDATA_IN[`TWM_CB_WCOL] == 1'b0) begin
          wcol <= 1'b0;
        end
        if (AVS_WRITEDATA_IN[`TWM_CB_STEP_DONE]) begin
          step_done <= 1'b0;
        end
      end
      if (dat_wr) begin
        if (step_done) begin
          data <= AVS_WRITEDATA_IN[7:0];
        end else begin
          wcol <= 1'b1;
        end
      end
      case (state)
        S_IDLE: begin
          sda_drv <= 1'b0;
          scl_drv <= 1'b0;
          owner <= 1'b0;
          if (go & w_sta & ~w_sto) begin
            state <= S_WAIT_FREE;
          end
        end
        S_WAIT_FREE: begin
          if (~bus_busy & scl & sda & tick) begin
            state <= S_START;
            phase <= 2'd0;
            rep <= 1'b0;
          end
        end
        S_START, S_RSTART: begin
          // repeated start first lifts data, then clock, then starts as normal
          if (tick) begin
            phase <= phase + 2'd1;
            if (state == S_RSTART && phase == 2'd0) begin
              sda_drv <= 1'b0;
            end else if (state == S_RSTART && phase == 2'd1) begin
              scl_drv <= 1'b0;
            end else if (state == S_RSTART && phase == 2'd2) begin
              phase <= 2'd0;
              state <= S_START;
            end else if (phase == 2'd0) begin
              sda_drv <= 1'b1;
            end else if (phase == 2'd1) begin
              scl_drv <= 1'b1;
              owner <= 1'b1;
              in_addr <= 1'b1;
              step_done <= 1'b1;
              status <= rep ? `TWM_ST_RSTART : `TWM_ST_START;
              state <= S_HOLD;
            end
          end
        end
        S_HOLD: begin
          // frozen until software clears the step flag: clock held low, or left released after arbitration loss
          if (go) begin
            phase <= 2'd0;
            if (status == `TWM_ST_ARB) begin
              state <= w_sta ? S_WAIT_FREE : S_IDLE;
              owner <= 1'b0;
            end else if (w_sto) begin
              state <= S_STOP;
            end else if (w_sta && !in_addr) begin
              state <= S_RSTART;
              rep <= 1'b1;
            end else begin
              shreg <= data;
              bitn <= 4'd0;
              state <= S_BIT;
            end
          end
        end
        S_BIT, S_ACK: begin
          if (tick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd0) begin
              sda_drv <= (state == S_BIT) ? ~shreg[7] : 1'b0;
            end else if (phase == 2'd1) begin
              scl_drv <= 1'b0;
            end else if (phase == 2'd2) begin
              if (state == S_BIT && ~shreg[7] == 1'b0 && ~sda) begin
                // lost arbitration: drop both lines, report
                sda_drv <= 1'b0;
                scl_drv <= 1'b0;
                owner <= 1'b0;
                status <= `TWM_ST_ARB;
                step_done <= 1'b1;
                state <= S_HOLD;
              end else if (state == S_ACK) begin
                if (in_addr & data[0]) begin
                  RECEIVER_MODE_OUT <= 1'b1;
                  status <= sda ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                end else if (in_addr) begin
                  RECEIVER_MODE_OUT <= 1'b0;
                  status <= sda ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
                end else begin
                  status <= sda ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
                end
                in_addr <= 1'b0;
              end
            end else begin
              scl_drv <= 1'b1;
              if (state == S_ACK) begin
                // flag only once the clock is held low, so nothing moves while it stands
                step_done <= 1'b1;
                state <= S_HOLD;
              end else if (bitn == 4'd7) begin
                state <= S_ACK;
              end else begin
                bitn <= bitn + 4'd1;
                shreg <= {shreg[6:0], 1'b1};
              end
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd0) begin
              sda_drv <= 1'b1;
            end else if (phase == 2'd1) begin
              scl_drv <= 1'b0;
            end else if (phase == 2'd2) begin
              sda_drv <= 1'b0;
              if (~(ctl_wr & w_sto)) begin
                stop_req <= 1'b0;
              end
              owner <= 1'b0;
              RECEIVER_MODE_OUT <= 1'b0;
              status <= `TWM_ST_IDLE;
              state <= start_req ? S_WAIT_FREE : S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // registered pin drive and interrupt
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      SCL_OE_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      SCL_OE_OUT <= scl_drv & enable;
      SDA_OE_OUT <= sda_drv & enable;
      IRQ_OUT <= step_done & irq_en;
    end
  end
endmodule

//--- test/twm_slave_model.sv
/* slave receiver on the two wires: captures each byte, answers in the ack slot.
 assumes resolved wire levels with pull-ups; no clock stretching. */
`timescale 1ns/1ns
module twm_slave_model (
  input wire scl_in,
  input wire sda_in,
  input wire ack_in,
  output reg sda_oe_out,
  output reg [7:0] byte_out
);
  integer bits = 0;
  initial sda_oe_out = 1'b0;
  initial byte_out = 8'h00;
  // ==========================================
  // framing: start resets the bit count
  always @(negedge sda_in) if (scl_in) bits = 0;
  always @(posedge scl_in) begin
    if (bits == 9) bits = 0;
    if (bits < 8) byte_out = {byte_out[6:0], sda_in};
    bits = bits + 1;
  end
  // low level in the ninth slot is an ack; released after it
  always @(negedge scl_in) sda_oe_out <= (bits == 8) && ack_in;
endmodule

//--- test/twm_master_checker.sv
/* port assertions for the two-wire master.
 assumes bind onto twm_master; quarter shortened in the bench. */
`timescale 1ns/1ns
module twm_master_checker #(parameter QUARTER = 4) (
  input wire CLK_IN,
  input wire RST_IN,
  input wire [3:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire [31:0] AVS_READDATA_OUT,
  input wire AVS_WAITREQUEST_OUT,
  input wire SCL_OE_OUT,
  input wire SDA_OE_OUT,
  input wire IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wire done = !AVS_WAITREQUEST_OUT;
  wire ctl_clr = AVS_WRITE_IN && done && AVS_ADDRESS_IN == 4'h0 && AVS_WRITEDATA_IN[7];
  // ==========================================
  // register bus and bus conditions
  property p_answer; $rose(AVS_READ_IN || AVS_WRITE_IN) |=> done; endproperty
  a_answer: assert property (p_answer) else $error("waitrequest not low one cycle after request");
  property p_one; done |=> !done; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_hole; AVS_READ_IN && done && !(AVS_ADDRESS_IN inside {4'h0, 4'h4, 4'h8}) |-> AVS_READDATA_OUT == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_mask; AVS_READ_IN && done && AVS_ADDRESS_IN == 4'h4 |-> AVS_READDATA_OUT[2:0] == 3'h0; endproperty
  a_mask: assert property (p_mask) else $error("status low bits set");
  property p_clear; ctl_clr |=> ##1 !IRQ_OUT; endproperty
  a_clear: assert property (p_clear) else $error("step flag not cleared");
  property p_freeze; IRQ_OUT && $past(IRQ_OUT) |-> $stable(SCL_OE_OUT) && $stable(SDA_OE_OUT); endproperty
  a_freeze: assert property (p_freeze) else $error("bus moved while step flag set");
  property p_start; $rose(SDA_OE_OUT) && !SCL_OE_OUT |-> ##[1:100] IRQ_OUT; endproperty
  a_start: assert property (p_start) else $error("no step flag after start");
  property p_stop; $fell(SDA_OE_OUT) && !SCL_OE_OUT |-> !IRQ_OUT[*4]; endproperty
  a_stop: assert property (p_stop) else $error("step flag right after stop");
  c_start: cover property ($rose(SDA_OE_OUT) && !SCL_OE_OUT);
  c_stop: cover property ($fell(SDA_OE_OUT) && !SCL_OE_OUT);
  c_freeze: cover property (IRQ_OUT [*8]);
endmodule
bind twm_master twm_master_checker #(.QUARTER(QUARTER)) chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .SCL_OE_OUT(SCL_OE_OUT), .SDA_OE_OUT(SDA_OE_OUT), .IRQ_OUT(IRQ_OUT));

//--- test/tb_top.sv
/* self-checking bench for the two-wire master transmitter.
 assumes a 100 MHz clock and a slave model on pulled-up wires. */
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, ack = 1, arb = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, seed = 32'h0000e95d;
  logic wq, scl_oe, sda_oe, s_oe, irq, rx;
  logic [7:0] got;
  int errors = 0, total_checks = 0, cyc = 0;
  // open drain: any enable pulls the wire low
  wire scl = !scl_oe;
  // arb stands for a second master pulling the data line low
  wire sda = !(sda_oe || s_oe || arb);
  always #5 clk = !clk;
  twm_master #(.QUARTER(4)) dut (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq),
    .SCL_IN(scl), .SCL_OE_OUT(scl_oe), .SCL_OUT(), .SDA_IN(sda), .SDA_OE_OUT(sda_oe), .SDA_OUT(),
    .IRQ_OUT(irq), .RECEIVER_MODE_OUT(rx));
  twm_slave_model slv (.scl_in(scl), .sda_in(sda), .ack_in(ack), .sda_oe_out(s_oe), .byte_out(got));
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] code(input logic is_adr, input logic [7:0] b, input logic a);
    if (!is_adr) return a ? 8'h28 : 8'h30;
    if (b[0]) return a ? 8'h40 : 8'h48;
    return a ? 8'h18 : 8'h20;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wq !== 1'b0);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // control write, then poll until the step flag comes back
  task automatic step(input logic [7:0] c, output logic [7:0] st);
    logic [7:0] q;
    acc(1'b1, 4'h0, c, q);
    q = 8'h00;
    while (q[7] !== 1'b1) acc(1'b0, 4'h0, 8'h00, q);
    acc(1'b0, 4'h4, 8'h00, st);
    chk("irq", {7'h0, irq}, 8'h01);
  endtask
  task automatic send(input logic is_adr, input logic [7:0] b, input logic a);
    logic [7:0] q;
    ack = a;
    acc(1'b1, 4'h8, b, q);
    step(8'h85, q);
    chk("status", q, code(is_adr, b, a));
    chk("wire byte", got, b);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] q, st;
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 4'h4, 8'h00, q);
    chk("idle status", q, 8'hf8);
    acc(1'b0, 4'hc, 8'h00, q);
    chk("unmapped", q, 8'h00);
    acc(1'b1, 4'h8, 8'h55, q);
    acc(1'b0, 4'h0, 8'h00, q);
    chk("collision", {7'h0, q[3]}, 8'h01);
    $display("register test done");
    step(8'ha5, st);
    chk("start", st, 8'h08);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      send(1'b1, {r[7:1], 1'b0}, i != 1);
      send(1'b0, r[15:8], r[16]);
      send(1'b0, r[23:16], !r[16]);
      case (i % 3)
        0: begin
          step(8'ha5, st);
          chk("repeated start", st, 8'h10);
        end
        1: begin
          step(8'hb5, st);
          chk("stop then start", st, 8'h08);
        end
        default: begin
          acc(1'b1, 4'h0, 8'h95, q);
          q = 8'hff;
          while (q[4] !== 1'b0) acc(1'b0, 4'h0, 8'h00, q);
          step(8'ha5, st);
          chk("start after stop", st, 8'h08);
        end
      endcase
      $display("transfer %0d done", i);
    end
    send(1'b1, 8'h5b, 1'b1);
    chk("receiver mode", {7'h0, rx}, 8'h01);
    $display("read address test done");
    // another master holds the data line low: the first address bit is lost
    acc(1'b1, 4'h0, 8'h95, q);
    q = 8'hff;
    while (q[4] !== 1'b0) acc(1'b0, 4'h0, 8'h00, q);
    step(8'ha5, st);
    chk("start before arbitration", st, 8'h08);
    arb <= 1'b1;
    acc(1'b1, 4'h8, 8'hf0, q);
    step(8'h85, st);
    chk("arbitration lost", st, 8'h38);
    fork
      step(8'ha5, st);
      begin
        repeat (200) @(posedge clk);
        chk("no start while bus busy", {7'h0, irq}, 8'h00);
        arb <= 1'b0;
      end
    join
    chk("start after bus free", st, 8'h08);
    arb <= 1'b1;
    acc(1'b1, 4'h8, 8'hf0, q);
    step(8'h85, st);
    chk("arbitration lost again", st, 8'h38);
    acc(1'b1, 4'h0, 8'h85, q);
    repeat (20) @(posedge clk);
    chk("bus released", {6'h0, scl_oe, sda_oe}, 8'h00);
    arb <= 1'b0;
    repeat (100) @(posedge clk);
    chk("no start after release", {6'h0, scl_oe, sda_oe}, 8'h00);
    $display("arbitration test done");
    summarize();
  end
endmodule
